// *** hw/ccd_bank.sv ***
// Purpose: AXI4-Lite module-disable register for capture/compare units
// Assumes: single clock, synchronous active-high reset
// Notes: converter disable bit and pin selects kept in a second register
`timescale 1ns/1ps
`default_nettype none
`include "ccd_regs.svh"
module ccd_bank
  import ccd_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 srst,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output ccd_units_t                unit_off,
  output logic                      converter_off,
  output logic [`CCD_PIN_W-1:0]     analog_pin_mode
);
  logic [15:0]           disable_ff, nxt_disable;
  logic                  conv_ff, nxt_conv;
  logic [`CCD_PIN_W-1:0] sel_ff, nxt_sel;
  logic                  aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic [11:0]           awa_ff, nxt_awa;
  logic [31:0]           wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [3:0]            ws_ff, nxt_ws;
  logic [1:0]            br_ff, nxt_br, rr_ff, nxt_rr;
  logic                  do_wr, do_rd;
  logic [15:0]           merged;
  // word indexes of the two registers; the low address bits only pick bytes
  localparam logic [9:0] IDX_DISABLE   = 10'(`CCD_OFS_DISABLE >> 2);
  localparam logic [9:0] IDX_CONVERTER = 10'(`CCD_OFS_CONVERTER >> 2);

  // address and data held separately; either may arrive first
  assign s_axi_awready = ~aw_ff & ~bv_ff;
  assign s_axi_wready  = ~w_ff & ~bv_ff;
  assign s_axi_arready = ~rv_ff;
  assign do_wr = aw_ff & w_ff & ~bv_ff;
  assign do_rd = s_axi_arvalid & ~rv_ff;

  // write path: byte lanes respected, unimplemented bits dropped
  always_comb begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_ws = ws_ff;
    nxt_bv = bv_ff;
    nxt_br = br_ff;
    nxt_disable = disable_ff;
    nxt_conv = conv_ff;
    nxt_sel = sel_ff;
    merged = disable_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
      nxt_ws = s_axi_wstrb;
    end
    if (do_wr) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = CCD_RESP_OKAY;
      if (awa_ff[11:2] == IDX_DISABLE) begin
        if (ws_ff[0]) merged[7:0] = wd_ff[7:0];
        if (ws_ff[1]) merged[15:8] = wd_ff[15:8];
        nxt_disable = merged & `CCD_DISABLE_MASK;
      end else if (awa_ff[11:2] == IDX_CONVERTER) begin
        if (ws_ff[0]) nxt_conv = wd_ff[`CCD_BIT_CONV_OFF];
        if (ws_ff[2]) nxt_sel[7:0] = wd_ff[23:16];
        if (ws_ff[3]) nxt_sel[`CCD_PIN_W-1:8] = wd_ff[16+`CCD_PIN_W-1:24];
      end else begin
        nxt_br = CCD_RESP_SLVERR;  // unmapped address
      end
    end
    if (bv_ff && s_axi_bready) nxt_bv = 1'b0;
  end

  // read path: one-cycle answer, unused bits read zero
  always_comb begin
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    if (do_rd) begin
      nxt_rv = 1'b1;
      nxt_rr = CCD_RESP_OKAY;
      if (s_axi_araddr[11:2] == IDX_DISABLE)
        nxt_rd = {16'h0000, disable_ff & `CCD_DISABLE_MASK};
      else if (s_axi_araddr[11:2] == IDX_CONVERTER)
        nxt_rd = {3'h0, sel_ff, 15'h0000, conv_ff};
      else begin
        nxt_rd = 32'h0000_0000;
        nxt_rr = CCD_RESP_SLVERR;
      end
    end else if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
  end

  // state registers; all disables clear so units start enabled
  always_ff @(posedge clock) begin
    if (srst) begin
      disable_ff <= `CCD_DISABLE_RST;
      conv_ff <= `CCD_CONV_RST;
      sel_ff <= '0;
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      bv_ff <= 1'b0;
      rv_ff <= 1'b0;
      awa_ff <= 12'h000;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      br_ff <= 2'h0;
      rr_ff <= 2'h0;
      rd_ff <= 32'h0000_0000;
    end else begin
      disable_ff <= nxt_disable;
      conv_ff <= nxt_conv;
      sel_ff <= nxt_sel;
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      bv_ff <= nxt_bv;
      rv_ff <= nxt_rv;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      ws_ff <= nxt_ws;
      br_ff <= nxt_br;
      rr_ff <= nxt_rr;
      rd_ff <= nxt_rd;
    end
  end

  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = br_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata = rd_ff;
  assign s_axi_rresp = rr_ff;

  // unit disables straight from the register bits
  assign unit_off.cap_eight = disable_ff[`CCD_BIT_CAP_EIGHT];
  assign unit_off.cap_seven = disable_ff[`CCD_BIT_CAP_SEVEN];
  assign unit_off.cap_two = disable_ff[`CCD_BIT_CAP_TWO];
  assign unit_off.cap_one = disable_ff[`CCD_BIT_CAP_ONE];
  assign unit_off.cmp_two = disable_ff[`CCD_BIT_CMP_TWO];
  assign unit_off.cmp_one = disable_ff[`CCD_BIT_CMP_ONE];
  assign converter_off = conv_ff;

  // one gate per shared analog pin
  for (genvar g = 0; g < `CCD_PIN_W; g++) begin : g_pin
    ccd_pin_gate u_gate (
      .conv_off    (conv_ff),
      .select_in   (sel_ff[g]),
      .analog_mode (analog_pin_mode[g])
    );
  end

  a_cap_eight_bit: assert property (@(posedge clock) disable iff (srst)
    do_wr && awa_ff[11:2] == 10'h000 && ws_ff[1] |=> unit_off.cap_eight == $past(wd_ff[15]))
    else $error("capture eight not written");
  a_cap_seven_bit: assert property (@(posedge clock) disable iff (srst)
    do_wr && awa_ff[11:2] == 10'h000 && ws_ff[1] |=> unit_off.cap_seven == $past(wd_ff[14]))
    else $error("capture seven not written");
  a_cap_two_bit: assert property (@(posedge clock) disable iff (srst)
    do_wr && awa_ff[11:2] == 10'h000 && ws_ff[1] |=> unit_off.cap_two == $past(wd_ff[9]))
    else $error("capture two not written");
  a_cap_one_bit: assert property (@(posedge clock) disable iff (srst)
    do_wr && awa_ff[11:2] == 10'h000 && ws_ff[1] |=> unit_off.cap_one == $past(wd_ff[8]))
    else $error("capture one not written");
  a_cmp_two_bit: assert property (@(posedge clock) disable iff (srst)
    do_wr && awa_ff[11:2] == 10'h000 && ws_ff[0] |=> unit_off.cmp_two == $past(wd_ff[1]))
    else $error("compare two not written");
  a_cmp_one_bit: assert property (@(posedge clock) disable iff (srst)
    do_wr && awa_ff[11:2] == 10'h000 && ws_ff[0] |=> unit_off.cmp_one == $past(wd_ff[0]))
    else $error("compare one not written");
  a_unused_zero: assert property (@(posedge clock) disable iff (srst)
    s_axi_rvalid && $past(s_axi_araddr[11:2]) == 10'h000 && $rose(s_axi_rvalid)
    |-> s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[13:10] == 4'h0
        && s_axi_rdata[7:2] == 6'h00) else $error("unused bits read nonzero");
  a_pins_digital: assert property (@(posedge clock) disable iff (srst)
    converter_off |-> analog_pin_mode == '0) else $error("analog pin while converter off");
  a_conv_release: assert property (@(posedge clock) disable iff (srst)
    $fell(converter_off) |-> analog_pin_mode == sel_ff) else $error("selection lost");
  a_reset_clear: assert property (@(posedge clock)
    srst |=> disable_ff == 16'h0000 && !conv_ff) else $error("reset did not clear");
  a_ready_after_reset: assert property (@(posedge clock)
    srst |=> s_axi_awready && s_axi_wready && s_axi_arready) else $error("ready low after reset");

  // a lane without its strobe keeps its old bits
  a_high_lane_kept: assert property (@(posedge clock) disable iff (srst)
    do_wr && awa_ff[11:2] == IDX_DISABLE && !ws_ff[1]
    |=> disable_ff[15:8] == $past(disable_ff[15:8])) else $error("high lane changed");
  a_low_lane_kept: assert property (@(posedge clock) disable iff (srst)
    do_wr && awa_ff[11:2] == IDX_DISABLE && !ws_ff[0]
    |=> disable_ff[7:0] == $past(disable_ff[7:0])) else $error("low lane changed");

  // answers come a fixed time after the handshakes; holes are refused
  a_write_answer: assert property (@(posedge clock) disable iff (srst)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (@(posedge clock) disable iff (srst)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response late");
  a_hole_read: assert property (@(posedge clock) disable iff (srst)
    do_rd && s_axi_araddr[11:2] > IDX_CONVERTER |=> s_axi_rresp == CCD_RESP_SLVERR
    && s_axi_rdata == 32'h0000_0000) else $error("hole read not refused");
  a_hole_write: assert property (@(posedge clock) disable iff (srst)
    do_wr && awa_ff[11:2] > IDX_CONVERTER |=> s_axi_bresp == CCD_RESP_SLVERR
    && $stable(disable_ff) && $stable(conv_ff) && $stable(sel_ff))
    else $error("hole write not refused");
endmodule : ccd_bank
`default_nettype wire

// *** hw/ccd_regs.svh ***
// Purpose: register map constants for the capture/compare module-disable bank
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: how it works follows
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH
`define CCD_OFS_DISABLE     12'h000
`define CCD_OFS_CONVERTER   12'h004
`define CCD_BIT_CAP_EIGHT   15
`define CCD_BIT_CAP_SEVEN   14
`define CCD_BIT_CAP_TWO     9
`define CCD_BIT_CAP_ONE     8
`define CCD_BIT_CMP_TWO     1
`define CCD_BIT_CMP_ONE     0
`define CCD_BIT_CONV_OFF    0
`define CCD_DISABLE_MASK    16'hc303
`define CCD_DISABLE_RST     16'h0000
`define CCD_CONV_RST        1'b0
`define CCD_PIN_W           13
`endif

// *** hw/ccd_pkg.sv ***
// Purpose: shared types for the capture/compare disable bank
// Assumes: ccd_regs.svh holds all register-map numbers; response codes are defined here
// Notes: none
package ccd_pkg;
  typedef enum logic [1:0] {
    CCD_RESP_OKAY   = 2'b00,
    CCD_RESP_SLVERR = 2'b10
  } ccd_resp_t;
  // one unit disable group fed to the peripherals
  typedef struct packed {
    logic cap_eight;
    logic cap_seven;
    logic cap_two;
    logic cap_one;
    logic cmp_two;
    logic cmp_one;
  } ccd_units_t;
endpackage : ccd_pkg

// *** hw/ccd_pin_gate.sv ***
// Purpose: per-pin analog/digital select, gated by the converter disable
// Assumes: select bit one means analog requested
// Notes: one instance per shared pin
`timescale 1ns/1ps
`default_nettype none
module ccd_pin_gate (
  input  wire logic conv_off,
  input  wire logic select_in,
  output logic      analog_mode
);
  // disabled converter overrides selection so the pin stays digital
  assign analog_mode = select_in & ~conv_off;
endmodule : ccd_pin_gate
`default_nettype wire

// *** verif/ccd_bank_tb.sv ***
// Purpose: self-checking bench for the capture/compare disable bank
// Assumes: ready outputs combinational, every answer within 50 cycles
// Notes: shadow copies of both registers give the expected values
`timescale 1ns/1ps
`default_nettype none
`include "ccd_regs.svh"
module ccd_bank_tb import ccd_pkg::*; ;
  logic        clock, srst;
  logic [11:0] s_axi_awaddr, s_axi_araddr, a;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, dis_e, conv_e;
  logic [3:0]  s_axi_wstrb, s;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  ccd_units_t  unit_off;
  logic        converter_off;
  logic [12:0] analog_pin_mode;
  int          fail_count, samples_checked, i;
  int unsigned seed;
  logic [11:0] cor_a [3] = '{12'h000, 12'h004, 12'h004};
  logic [31:0] cor_d [3] = '{32'hffffffff, 32'hffffffff, 32'h1fff0000};

  ccd_bank ccd_bank_inst (.clock, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .unit_off, .converter_off, .analog_pin_mode);

  // 40 mhz clock
  always #12.5 clock = ~clock;

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk_data

  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk_resp

  // byte lanes limited to the implemented bits
  function automatic logic [31:0] upd(input logic [31:0] o, n, input logic [3:0] b,
                                      input logic [31:0] m);
    logic [31:0] k;
    k = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & m;
    return (o & ~k) | (n & k);
  endfunction : upd

  // each channel dropped on its own handshake; trailing idle edge avoids double drive
  task automatic axi_wr(input logic [11:0] wa, input logic [31:0] wd, input logic [3:0] ws);
    int n;
    s_axi_awaddr <= wa;
    s_axi_wdata <= wd;
    s_axi_wstrb <= ws;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      fail_count++;
      finish_test();
    end
    @(posedge clock);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] ra);
    int n;
    s_axi_araddr <= ra;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      fail_count++;
      finish_test();
    end
    @(posedge clock);
  endtask : axi_rd

  // readback of both registers, a hole, and the level outputs
  task automatic check_all();
    axi_rd(`CCD_OFS_DISABLE);
    chk_data("disable_reg", dis_e, d);
    chk_resp("rresp", CCD_RESP_OKAY, r);
    axi_rd(`CCD_OFS_CONVERTER);
    chk_data("converter_reg", conv_e, d);
    axi_rd(12'h008);
    chk_data("hole_data", 32'h0, d);
    chk_resp("hole_resp", CCD_RESP_SLVERR, r);
    chk_data("unit_off", {26'h0, dis_e[15:14], dis_e[9:8], dis_e[1:0]}, {26'h0, unit_off});
    chk_data("converter_off", {31'h0, conv_e[0]}, {31'h0, converter_off});
    chk_data("pin_mode", {19'h0, conv_e[28:16] & {13{~conv_e[0]}}}, {19'h0, analog_pin_mode});
  endtask : check_all

  // corners first, then random offsets, data and strobes
  initial begin
    {clock, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {fail_count, samples_checked, dis_e, conv_e} = '0;
    srst = 1'b1;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    seed = $urandom(32'h774c);
    check_all();
    for (i = 0; i < 40; i++) begin
      a = 12'(4 * $urandom_range(0, 2));
      d = $urandom;
      s = 4'($urandom);
      if (i < 3) begin
        a = cor_a[i];
        d = cor_d[i];
        s = 4'hf;
      end
      axi_wr(a, d, s);
      chk_resp("bresp", (a > 12'h004) ? CCD_RESP_SLVERR : CCD_RESP_OKAY, r);
      if (a == `CCD_OFS_DISABLE) dis_e = upd(dis_e, d, s, {16'h0, `CCD_DISABLE_MASK});
      if (a == `CCD_OFS_CONVERTER) conv_e = upd(conv_e, d, s, 32'h1fff0001);
      check_all();
    end
    // second reset in mid-run must clear every disable bit
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    {dis_e, conv_e} = '0;
    check_all();
    finish_test();
  end
endmodule : ccd_bank_tb
`default_nettype wire
